// *** rtl/mdri_ahb_slave.sv ***
`timescale 1ns/1ps
module mdri_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  mdri_regbus_if.master rb
);
  mdri_pkg::mdri_ahb_st_t st;  // Slave state
  logic wph;                   // Write data phase pending
  logic rd_map;                // Read hits the register window
  logic [6:0] idx;             // Captured index
  wire take = hsel & hready & htrans[1];  // Address phase accepted
  wire in_map = (haddr[31:9] == 23'h000000);

  assign rb.idx = idx;
  assign rb.wr = wph;
  assign rb.rd = (st == mdri_pkg::AHB_RD1);
  assign rb.wdata = hwdata[7:0];

  // Zero-wait writes, two wait states on reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= mdri_pkg::AHB_IDLE;
      wph <= 1'b0;
      rd_map <= 1'b0;
      idx <= 7'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (st)
        mdri_pkg::AHB_IDLE: begin
          wph <= take & hwrite & in_map;
          if (take) begin
            idx <= haddr[8:2];
          end
          if (take && !hwrite) begin
            st <= mdri_pkg::AHB_RD1;
            rd_map <= in_map;
            hreadyout <= 1'b0;
          end
        end
        mdri_pkg::AHB_RD1: begin
          st <= mdri_pkg::AHB_RD2;
        end
        mdri_pkg::AHB_RD2: begin
          hrdata <= rd_map ? {24'h000000, rb.rdata} : 32'h00000000;
          hreadyout <= 1'b1;
          st <= mdri_pkg::AHB_IDLE;
        end
        default: begin
          st <= mdri_pkg::AHB_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_take;
    take && !hwrite && st == mdri_pkg::AHB_IDLE;
  endsequence
  sequence s_rd_answer;
    !hreadyout ##1 !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (s_rd_take |=> s_rd_answer)
    else $error("read answer timing wrong");
endmodule : mdri_ahb_slave

// *** rtl/mdri_byte_mem.sv ***
`timescale 1ns/1ps
module mdri_byte_mem #(
  parameter int DEPTH = 21,
  parameter int AW = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];  // Byte store, cleared at power-on

  // Write port and registered read port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
      rdata <= 8'h00;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : mdri_byte_mem

// *** rtl/mdri_defines.svh ***
`ifndef MDRI_DEFINES_SVH
`define MDRI_DEFINES_SVH
// Register indexes; byte address is four times the index
`define MDRI_IDX_WDC 7'h00
`define MDRI_IDX_MC 7'h01
`define MDRI_IDX_MS 7'h03
`define MDRI_IDX_SEE 7'h04
`define MDRI_IDX_WDS 7'h05
`define MDRI_IDX_GPM0 7'h06
`define MDRI_IDX_LOCK 7'h0A
`define MDRI_IDX_SUPC 7'h10
`define MDRI_IDX_SUPS 7'h1B
`define MDRI_IDX_SUPPLY_EVENT_SUMMARY 7'h1C
`define MDRI_IDX_CANC 7'h20
`define MDRI_IDX_TRXS 7'h22
`define MDRI_IDX_TRXEE 7'h23
`define MDRI_IDX_DR 7'h26
`define MDRI_IDX_PNID0 7'h27
`define MDRI_IDX_FC 7'h2F
`define MDRI_IDX_GEV 7'h60
`define MDRI_IDX_SEV 7'h61
`define MDRI_IDX_VEV 7'h62
`define MDRI_IDX_TEV 7'h63
`define MDRI_IDX_DM0 7'h68
`define MDRI_IDX_NVS 7'h70
`define MDRI_IDX_STC 7'h73
`define MDRI_IDX_CFG 7'h74
`define MDRI_IDX_CRC 7'h75
`define MDRI_IDX_ID 7'h7E
// Byte memory slots and counts
`define MDRI_N_GPM 7'h04
`define MDRI_N_PNID 7'h08
`define MDRI_N_DM 7'h08
`define MDRI_SLOT_PNID 5'h04
`define MDRI_SLOT_DM 5'h0C
`define MDRI_SLOT_CRC 5'h14
// Reset and load values
`define MDRI_MC_STBY 3'h4
`define MDRI_MC_NORM 3'h7
`define MDRI_MC_SLEEP 3'h1
`define MDRI_RST_CDR 3'h5
`define MDRI_RST_NWP 4'h4
`define MDRI_RSS_OT 5'h12
`define MDRI_WMC_DEV 3'h1
`define MDRI_WMC_STD 3'h2
`define MDRI_RST_FC 8'h40
`endif

// *** rtl/mdri_pkg.sv ***
package mdri_pkg;
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_OFF = 6'h01,
    MODE_STANDBY = 6'h02,
    MODE_NORMAL = 6'h04,
    MODE_SLEEP = 6'h08,
    MODE_OVERTEMP = 6'h10,
    MODE_RESET = 6'h20
  } mdri_mode_t;
  // Bus slave states, one-hot
  typedef enum logic [2:0] {
    AHB_IDLE = 3'h1,
    AHB_RD1 = 3'h2,
    AHB_RD2 = 3'h4
  } mdri_ahb_st_t;
endpackage : mdri_pkg

// *** rtl/mdri_regbus_if.sv ***
`timescale 1ns/1ps
interface mdri_regbus_if;
  logic [6:0] idx;   // Register index of current access
  logic wr;          // Write strobe, one cycle
  logic rd;          // Read launch, one cycle
  logic [7:0] wdata; // Write byte
  logic [7:0] rdata; // Read byte from register bank
  modport master (output idx, wr, rd, wdata, input rdata);
  modport slave (input idx, wr, rd, wdata, output rdata);
endinterface : mdri_regbus_if

// *** rtl/mdri_top.sv ***
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "mdri_defines.svh"
module mdri_top #(
  parameter logic [7:0] PART_IDENT = 8'hA5  // Arbitrary identification value
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mode_enter,
  input wire mdri_pkg::mdri_mode_t mode_next,
  input wire logic [4:0] reset_cause_code,
  input wire logic live_tx_active,
  input wire logic live_bus_silent,
  input wire logic live_txd_failure,
  input wire logic live_osc,
  input wire logic live_pn_error,
  input wire logic live_pn_config,
  input wire logic live_first_normal,
  input wire logic live_dev_mode,
  input wire logic live_overtemp_warn,
  input wire logic live_reg_supply,
  input wire logic [1:0] live_sensor_supply,
  input wire logic live_bus_voltage,
  input wire logic live_watchdog,
  input wire logic nv_first_normal_cfg,
  input wire logic nv_dev_mode_cfg,
  input wire logic nv_sleep_disable_cfg,
  input wire logic [1:0] nv_reset_length_cfg,
  input wire logic [1:0] nv_reg_threshold_startup,
  input wire logic [1:0] nv_sensor_supply_startup,
  input wire logic nv_correction_state,
  input wire logic nv_programmed_state,
  input wire logic [5:0] nv_write_count,
  input wire logic evt_serial_fault,
  input wire logic evt_overtemp_warn,
  input wire logic evt_reg_undervolt,
  input wire logic evt_bus_wake,
  input wire logic evt_can_failure,
  input wire logic evt_bus_silence,
  input wire logic evt_fd_frame_error,
  output logic [2:0] op_mode_ctrl,
  output logic [1:0] transceiver_mode_ctrl,
  output logic [3:0] watchdog_period,
  output logic [2:0] watchdog_mode,
  output logic pn_enable_ctrl,
  output logic [1:0] reg_threshold_ctrl,
  output logic [1:0] sensor_supply_ctrl
);
  mdri_regbus_if rb ();
  mdri_pkg::mdri_mode_t cur_mode;  // Mode in force
  logic boot;                      // First cycle after reset release
  logic normal_entry_flag;
  logic [4:0] reset_cause;
  logic [2:0] pn_bitrate_sel;
  logic fd_tolerance_ctrl, pn_cfg_valid;
  logic [6:0] region_lock;
  logic [7:0] frame_ctrl;          // Ident select, mask enable, length
  logic [2:0] trx_enables;         // Silence, failure, wake enables
  logic [1:0] sys_enables;         // Overtemp, serial fault enables
  logic reg_undervolt_enable;
  logic [7:0] live_q;              // Transceiver status byte
  logic [3:0] wd_live_q;           // Overtemp warning, first normal, dev mode, watchdog
  logic [2:0] sup_live_q;          // Sensor supply, regulator supply
  logic [2:0] sys_evt;             // Power-on, overtemp, serial fault
  logic [3:0] trx_evt;             // Fd error, silence, failure, wake
  logic reg_undervolt_event;
  logic [2:0] glob_evt;            // Transceiver, supply, system summary
  logic [7:0] mem_rdata, rdata_mux;

  // Sticky flag: a set in the same cycle as a clear wins
  function automatic logic [3:0] mdri_w1c(input logic [3:0] q, input logic [3:0] s,
                                          input logic [3:0] c);
    mdri_w1c = s | (q & ~c);
  endfunction : mdri_w1c

  // Byte memory slot of an index: {hit, slot}
  function automatic logic [5:0] mdri_slot(input logic [6:0] i);
    logic [6:0] o_g, o_p, o_d;
    o_g = i - `MDRI_IDX_GPM0;
    o_p = i - `MDRI_IDX_PNID0;
    o_d = i - `MDRI_IDX_DM0;
    if (o_g < `MDRI_N_GPM) mdri_slot = {1'b1, o_g[4:0]};
    else if (o_p < `MDRI_N_PNID) mdri_slot = {1'b1, o_p[4:0] + `MDRI_SLOT_PNID};
    else if (o_d < `MDRI_N_DM) mdri_slot = {1'b1, o_d[4:0] + `MDRI_SLOT_DM};
    else if (i == `MDRI_IDX_CRC) mdri_slot = {1'b1, `MDRI_SLOT_CRC};
    else mdri_slot = 6'h00;
  endfunction : mdri_slot

  // Bus front end
  mdri_ahb_slave u_ahb (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rb(rb.master)
  );

  // Write qualification and decode
  wire wr_ok = rb.wr & ~mode_enter;
  wire [5:0] wslot = mdri_slot(rb.idx);  // Slot shared by write and read paths
  wire [7:0] wd = rb.wdata;
  wire w_wdc = wr_ok & (rb.idx == `MDRI_IDX_WDC);
  wire w_mc = wr_ok & (rb.idx == `MDRI_IDX_MC);
  wire w_see = wr_ok & (rb.idx == `MDRI_IDX_SEE);
  wire w_lock = wr_ok & (rb.idx == `MDRI_IDX_LOCK);
  wire w_supc = wr_ok & (rb.idx == `MDRI_IDX_SUPC);
  wire w_supply_event_summary = wr_ok & (rb.idx == `MDRI_IDX_SUPPLY_EVENT_SUMMARY);
  wire w_canc = wr_ok & (rb.idx == `MDRI_IDX_CANC);
  wire w_trxee = wr_ok & (rb.idx == `MDRI_IDX_TRXEE);
  wire w_dr = wr_ok & (rb.idx == `MDRI_IDX_DR);
  wire w_fc = wr_ok & (rb.idx == `MDRI_IDX_FC);
  wire w_gev = wr_ok & (rb.idx == `MDRI_IDX_GEV);
  wire w_sev = wr_ok & (rb.idx == `MDRI_IDX_SEV);
  wire w_vev = wr_ok & (rb.idx == `MDRI_IDX_VEV);
  wire w_tev = wr_ok & (rb.idx == `MDRI_IDX_TEV);
  wire w_mem = wr_ok & wslot[5];
  wire ent_normal = mode_enter & (mode_next == mdri_pkg::MODE_NORMAL);
  wire ent_reset = mode_enter & (mode_next == mdri_pkg::MODE_RESET);
  wire ent_ot = mode_enter & (mode_next == mdri_pkg::MODE_OVERTEMP);
  wire ent_stby = mode_enter & (mode_next == mdri_pkg::MODE_STANDBY);
  wire ent_sleep = mode_enter & (mode_next == mdri_pkg::MODE_SLEEP);
  wire [2:0] wmc_load = nv_dev_mode_cfg ? `MDRI_WMC_DEV : `MDRI_WMC_STD;
  wire [2:0] sys_set = {1'b0, evt_overtemp_warn & sys_enables[1],
                        evt_serial_fault & sys_enables[0]};
  wire [3:0] trx_set = {evt_fd_frame_error, evt_bus_silence & trx_enables[2],
                        evt_can_failure & trx_enables[1], evt_bus_wake & trx_enables[0]};
  wire sup_set = evt_reg_undervolt & reg_undervolt_enable;

  // Byte store for identifier, masks, scratch and checksum bytes
  mdri_byte_mem #(.DEPTH(21), .AW(5)) u_mem (
    .hclk(hclk), .hresetn(hresetn), .we(w_mem), .waddr(wslot[4:0]),
    .wdata(wd), .raddr(wslot[4:0]), .rdata(mem_rdata)
  );

  // Mode-driven fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_mode <= mdri_pkg::MODE_OFF;
      boot <= 1'b1;
      op_mode_ctrl <= `MDRI_MC_STBY;
      normal_entry_flag <= 1'b1;
      watchdog_period <= `MDRI_RST_NWP;
      reset_cause <= 5'h00;
      watchdog_mode <= `MDRI_WMC_STD;
      reg_threshold_ctrl <= 2'h0;
      sensor_supply_ctrl <= 2'h0;
    end else begin
      boot <= 1'b0;
      if (mode_enter) begin
        cur_mode <= mode_next;
      end
      // Power-on loads taken right after reset release
      if (boot) begin
        watchdog_mode <= wmc_load;
        reg_threshold_ctrl <= nv_reg_threshold_startup;
        sensor_supply_ctrl <= nv_sensor_supply_startup;
      end else if (ent_reset) begin
        watchdog_mode <= wmc_load;
      end else if (w_wdc) begin
        watchdog_mode <= wd[7:5];
      end
      if (w_supc) begin
        reg_threshold_ctrl <= wd[1:0];
        sensor_supply_ctrl <= wd[3:2];
      end
      // Mode field per entered mode, Overtemp keeps it
      if (ent_stby || ent_reset) begin
        op_mode_ctrl <= `MDRI_MC_STBY;
      end else if (ent_normal) begin
        op_mode_ctrl <= `MDRI_MC_NORM;
      end else if (ent_sleep) begin
        op_mode_ctrl <= `MDRI_MC_SLEEP;
      end else if (w_mc) begin
        op_mode_ctrl <= wd[2:0];
      end
      if (ent_normal) begin
        normal_entry_flag <= 1'b0;
      end
      if (ent_ot || ent_reset) begin
        watchdog_period <= `MDRI_RST_NWP;
      end else if (w_wdc) begin
        watchdog_period <= wd[3:0];
      end
      if (ent_ot) begin
        reset_cause <= `MDRI_RSS_OT;
      end else if (ent_reset) begin
        reset_cause <= reset_cause_code;
      end
    end
  end

  // Software controls, untouched by mode changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pn_bitrate_sel <= `MDRI_RST_CDR;
      transceiver_mode_ctrl <= 2'h0;
      {fd_tolerance_ctrl, pn_cfg_valid, pn_enable_ctrl} <= 3'h0;
      region_lock <= 7'h00;
      trx_enables <= 3'h0;
      sys_enables <= 2'h0;
      reg_undervolt_enable <= 1'b0;
      frame_ctrl <= `MDRI_RST_FC;
    end else begin
      if (w_dr) pn_bitrate_sel <= wd[2:0];
      if (w_canc) begin
        transceiver_mode_ctrl <= wd[1:0];
        {fd_tolerance_ctrl, pn_cfg_valid, pn_enable_ctrl} <= wd[6:4];
      end
      if (w_lock) region_lock <= wd[6:0];
      if (w_trxee) trx_enables <= {wd[4], wd[1:0]};
      if (w_see) sys_enables <= wd[2:1];
      if (w_supply_event_summary) reg_undervolt_enable <= wd[0];
      if (w_fc) frame_ctrl <= {wd[7:6], 2'h0, wd[3:0]};
    end
  end

  // Live status capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_q <= 8'h48;  // Silence 1, pn error 1
      wd_live_q <= 4'h0;
      sup_live_q <= 3'h0;
    end else begin
      live_q[7] <= (cur_mode == mdri_pkg::MODE_NORMAL) & live_tx_active;
      if (cur_mode != mdri_pkg::MODE_SLEEP) begin
        live_q[3] <= live_bus_silent;
      end
      {live_q[6:4], live_q[2:0]} <= {live_pn_error, live_pn_config, live_osc,
                                     1'b0, live_bus_voltage, live_txd_failure};
      wd_live_q <= {live_overtemp_warn, live_first_normal, live_dev_mode, live_watchdog};
      sup_live_q <= {live_sensor_supply, live_reg_supply};
    end
  end

  // Captured events, write one to clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_evt <= 3'h4;
      trx_evt <= 4'h0;
      reg_undervolt_event <= 1'b0;
      glob_evt <= 3'h1;
    end else begin
      sys_evt <= 3'(mdri_w1c({1'b0, sys_evt}, {1'b0, sys_set}, {1'b0, w_sev ? wd[4] : 1'b0,
                                                      w_sev ? wd[2:1] : 2'h0}));
      trx_evt <= mdri_w1c(trx_evt, trx_set, w_tev ? {wd[5:4], wd[1:0]} : 4'h0);
      reg_undervolt_event <= sup_set | (reg_undervolt_event & ~(w_vev & wd[0]));
      glob_evt <= 3'(mdri_w1c({1'b0, glob_evt}, {1'b0, |trx_set, sup_set, |sys_set},
                              w_gev ? {1'b0, wd[2:0]} : 4'h0));
    end
  end

  // Read data selection
  always_comb begin
    case (rb.idx)
      `MDRI_IDX_WDC: rdata_mux = {watchdog_mode, 1'b0, watchdog_period};
      `MDRI_IDX_MC: rdata_mux = {5'h00, op_mode_ctrl};
      `MDRI_IDX_MS: rdata_mux = {1'b0, wd_live_q[3], normal_entry_flag, reset_cause};
      `MDRI_IDX_SEE: rdata_mux = {5'h00, sys_enables, 1'b0};
      `MDRI_IDX_WDS: rdata_mux = {5'h00, wd_live_q[2:0]};
      `MDRI_IDX_LOCK: rdata_mux = {1'b0, region_lock};
      `MDRI_IDX_SUPC: rdata_mux = {4'h0, sensor_supply_ctrl, reg_threshold_ctrl};
      `MDRI_IDX_SUPS: rdata_mux = {5'h00, sup_live_q};
      `MDRI_IDX_SUPPLY_EVENT_SUMMARY: rdata_mux = {7'h00, reg_undervolt_enable};
      `MDRI_IDX_CANC: rdata_mux = {1'b0, fd_tolerance_ctrl, pn_cfg_valid, pn_enable_ctrl,
                                   2'h0, transceiver_mode_ctrl};
      `MDRI_IDX_TRXS: rdata_mux = live_q;
      `MDRI_IDX_TRXEE: rdata_mux = {3'h0, trx_enables[2], 2'h0, trx_enables[1:0]};
      `MDRI_IDX_DR: rdata_mux = {5'h00, pn_bitrate_sel};
      `MDRI_IDX_FC: rdata_mux = frame_ctrl;
      `MDRI_IDX_GEV: rdata_mux = {5'h00, glob_evt};
      `MDRI_IDX_SEV: rdata_mux = {3'h0, sys_evt[2], 1'b0, sys_evt[1:0], 1'b0};
      `MDRI_IDX_VEV: rdata_mux = {7'h00, reg_undervolt_event};
      `MDRI_IDX_TEV: rdata_mux = {2'h0, trx_evt[3:2], 2'h0, trx_evt[1:0]};
      `MDRI_IDX_NVS: rdata_mux = {nv_write_count, nv_correction_state,
                                  nv_programmed_state};
      `MDRI_IDX_STC: rdata_mux = {2'h0, nv_reset_length_cfg, nv_sensor_supply_startup,
                                  2'h0};
      `MDRI_IDX_CFG: rdata_mux = {2'h0, nv_reg_threshold_startup, nv_first_normal_cfg,
                                  nv_dev_mode_cfg, 1'b0, nv_sleep_disable_cfg};
      `MDRI_IDX_ID: rdata_mux = PART_IDENT;
      default: rdata_mux = wslot[5] ? mem_rdata : 8'h00;
    endcase
  end
  assign rb.rdata = rdata_mux;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_clash;
    mode_enter ##0 rb.wr;
  endsequence
  a_clash_discard: assert property (s_clash |=> $stable(pn_bitrate_sel))
    else $error("write applied during mode update");
  a_cdr_kept: assert property (mode_enter |=> $stable(pn_bitrate_sel))
    else $error("bit-rate select changed by mode");
  a_xcvr_kept: assert property (mode_enter |=> $stable(transceiver_mode_ctrl))
    else $error("transceiver mode changed by mode");
  a_tx_zero: assert property (cur_mode != mdri_pkg::MODE_NORMAL |=> !live_q[7])
    else $error("transmitter active outside normal");
  a_silence_hold: assert property (cur_mode==mdri_pkg::MODE_SLEEP |=> $stable(live_q[3]))
    else $error("bus silence moved in sleep");
  a_mode_field: assert property (ent_stby || ent_normal || ent_sleep || ent_reset |=>
                                 op_mode_ctrl == ($past(ent_normal) ? `MDRI_MC_NORM :
                                 ($past(ent_sleep) ? `MDRI_MC_SLEEP : `MDRI_MC_STBY)))
    else $error("mode field wrong after mode entry");
  a_entry_clear: assert property (ent_normal |=> !normal_entry_flag)
    else $error("normal entry flag not cleared");
  a_wdp_load: assert property (ent_ot || ent_reset |=> watchdog_period == `MDRI_RST_NWP)
    else $error("watchdog period not loaded");
  a_cause_ot: assert property (ent_ot |=> reset_cause == `MDRI_RSS_OT)
    else $error("reset cause not overtemp code");
  a_wdm_reset: assert property (ent_reset |=> watchdog_mode ==
                                ($past(nv_dev_mode_cfg) ? `MDRI_WMC_DEV : `MDRI_WMC_STD))
    else $error("watchdog mode wrong after reset");
endmodule : mdri_top

// *** test/mdri_host.sv ***
`timescale 1ns/1ps
// Host side of the register bus: one single word transfer at a time
module mdri_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);
  int n_to = 0; // Waits that ran out

  // Bus idle at time zero
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  // Waits for hready high at a rising edge, bounded so a hang cannot stall the run
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_to++;
    end
  endtask : wait_rdy

  // Address phase held until taken, then data phase held until done
  task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {23'h0, idx, 2'h0};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata[7:0];
  endtask : xfer
endmodule : mdri_host

// *** test/mdri_top_test.sv ***
`timescale 1ns/1ps
module mdri_top_test;
  logic hclk = 1'b0; // Bus clock
  logic hresetn = 1'b0; // Reset, active low
  logic mode_enter = 1'b0; // Mode entry pulse
  mdri_pkg::mdri_mode_t mode_next = mdri_pkg::MODE_OFF; // Mode being entered
  logic [4:0] reset_cause_code = 5'h00; // Cause loaded on Reset entry
  logic live_tx_active = 1'b0, live_bus_silent = 1'b1, live_pn_error = 1'b1;
  logic live_txd_failure, live_osc, live_pn_config, live_first_normal, live_dev_mode;
  logic live_overtemp_warn, live_reg_supply, live_bus_voltage, live_watchdog;
  logic evt_serial_fault, evt_overtemp_warn, evt_reg_undervolt, evt_bus_wake;
  logic evt_can_failure, evt_bus_silence, evt_fd_frame_error;
  logic [1:0] live_sensor_supply = 2'h0;
  logic nv_first_normal_cfg = 1'b0, nv_dev_mode_cfg = 1'b1, nv_sleep_disable_cfg = 1'b1;
  logic nv_correction_state = 1'b1, nv_programmed_state = 1'b0;
  logic [1:0] nv_reset_length_cfg = 2'h0, nv_reg_threshold_startup = 2'h2;
  logic [1:0] nv_sensor_supply_startup = 2'h1;
  logic [5:0] nv_write_count = 6'h15;
  logic [31:0] haddr, hwdata, hrdata; // Bus lines
  logic [1:0] htrans, transceiver_mode_ctrl, reg_threshold_ctrl, sensor_supply_ctrl;
  logic hwrite, hreadyout, pn_enable_ctrl;
  logic [2:0] op_mode_ctrl, watchdog_mode;
  logic [3:0] watchdog_period;
  int n_errors = 0; // Mismatches
  int num_checks = 0; // Comparisons
  // Rows: register index in the upper byte, expected byte after reset below it
  logic [15:0] rows [17] = '{16'h2605, 16'h2000, 16'h0104, 16'h0024, 16'h0320, 16'h2F40,
    16'h6110, 16'h6001, 16'h6300, 16'h0600, 16'h7500, 16'h2248, 16'h7425, 16'h7304,
    16'h1006, 16'h7056, 16'h1100};

  mdri_host mdri_host_inst (.hclk, .hready(hreadyout), .hrdata, .haddr, .htrans, .hwrite,
    .hwdata);

  mdri_top mdri_top_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(), .mode_enter,
    .mode_next, .reset_cause_code, .live_tx_active, .live_bus_silent, .live_txd_failure,
    .live_osc, .live_pn_error, .live_pn_config, .live_first_normal, .live_dev_mode,
    .live_overtemp_warn, .live_reg_supply, .live_sensor_supply, .live_bus_voltage,
    .live_watchdog, .nv_first_normal_cfg, .nv_dev_mode_cfg, .nv_sleep_disable_cfg,
    .nv_reset_length_cfg, .nv_reg_threshold_startup, .nv_sensor_supply_startup,
    .nv_correction_state, .nv_programmed_state, .nv_write_count, .evt_serial_fault,
    .evt_overtemp_warn, .evt_reg_undervolt, .evt_bus_wake, .evt_can_failure,
    .evt_bus_silence, .evt_fd_frame_error, .op_mode_ctrl, .transceiver_mode_ctrl,
    .watchdog_period, .watchdog_mode, .pn_enable_ctrl, .reg_threshold_ctrl,
    .sensor_supply_ctrl);

  // 40 MHz clock
  always #12.5 hclk = ~hclk;

  // Verdict and end of run
  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Compares one value, zero-extended to a byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer; a hung handshake ends the run
  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    mdri_host_inst.xfer(w, idx, d, q);
    if (mdri_host_inst.n_to > 0) begin
      n_errors++;
      results();
    end
  endtask : bus

  // Reads a register and compares it
  task automatic rchk(input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask : rchk

  // Writes a register
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  // Enters a mode and waits until the update has settled
  task automatic go(input mdri_pkg::mdri_mode_t m);
    @(posedge hclk);
    mode_enter <= 1'b1;
    mode_next <= m;
    @(posedge hclk);
    mode_enter <= 1'b0;
    @(negedge hclk);
  endtask : go

  // Write whose data phase meets a Standby entry
  task automatic clash(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    fork
      bus(1'b1, idx, d, q);
      begin
        repeat (2) @(posedge hclk);
        mode_enter <= 1'b1;
        mode_next <= mdri_pkg::MODE_STANDBY;
        @(posedge hclk);
        mode_enter <= 1'b0;
      end
    join
  endtask : clash

  // Main sequence
  initial begin
    {live_txd_failure, live_osc, live_pn_config, live_first_normal, live_dev_mode,
      live_overtemp_warn, live_reg_supply, live_bus_voltage, live_watchdog, evt_serial_fault,
      evt_overtemp_warn, evt_reg_undervolt, evt_bus_wake, evt_can_failure, evt_bus_silence,
      evt_fd_frame_error} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      rchk(rows[i][14:8], rows[i][7:0]);
    end
    wr(7'h26, 8'h03);
    wr(7'h20, 8'h12);
    wr(7'h00, 8'h49);
    @(posedge hclk);
    evt_fd_frame_error <= 1'b1;
    live_tx_active <= 1'b1;
    @(posedge hclk);
    evt_fd_frame_error <= 1'b0;
    go(mdri_pkg::MODE_NORMAL);
    chk(8'(op_mode_ctrl), 8'h07);
    chk(8'(transceiver_mode_ctrl), 8'h02);
    chk(8'(watchdog_period), 8'h09);
    chk(8'(pn_enable_ctrl), 8'h01);
    rchk(7'h26, 8'h03);
    rchk(7'h03, 8'h00);
    rchk(7'h22, 8'hC8);
    rchk(7'h63, 8'h20);
    go(mdri_pkg::MODE_SLEEP);
    chk(8'(op_mode_ctrl), 8'h01);
    @(posedge hclk);
    live_bus_silent <= 1'b0;
    rchk(7'h22, 8'h48);
    live_overtemp_warn <= 1'b1;
    go(mdri_pkg::MODE_OVERTEMP);
    chk(8'(watchdog_period), 8'h04);
    chk(8'(watchdog_mode), 8'h02);
    rchk(7'h03, 8'h52);
    rchk(7'h22, 8'h40);
    reset_cause_code <= 5'h0B;
    live_overtemp_warn <= 1'b0;
    go(mdri_pkg::MODE_RESET);
    chk(8'(watchdog_mode), 8'h01);
    chk(8'(op_mode_ctrl), 8'h04);
    rchk(7'h03, 8'h0B);
    clash(7'h06, 8'h5A);
    rchk(7'h06, 8'h00);
    clash(7'h26, 8'h02);
    rchk(7'h26, 8'h03);
    wr(7'h06, 8'hA5);
    rchk(7'h06, 8'hA5);
    wr(7'h26, 8'h02);
    wr(7'h00, 8'h49);
    wr(7'h01, 8'h07);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk(8'(watchdog_period), 8'h04);
    chk(8'(op_mode_ctrl), 8'h04);
    @(posedge hclk);
    hresetn <= 1'b1;
    rchk(7'h00, 8'h24);
    rchk(7'h26, 8'h05);
    rchk(7'h03, 8'h20);
    results();
  end
endmodule : mdri_top_test
